/* design/eccd_map.vh */
`ifndef ECCD_MAP_VH
`define ECCD_MAP_VH
`define ECCD_ADDR_W 20
`define ECCD_BLK_LSB 16
`define ECCD_PRI_SER_BASE 10'h3F8
`define ECCD_SEC_SER_BASE 10'h2F8
`define ECCD_PRI_PRN_BASE 10'h3BC
`define ECCD_SEC_PRN_BASE 10'h378
`define ECCD_CLK_BASE 10'h2C0
`define ECCD_SER_MASK 10'h3F8
`define ECCD_PRN_MASK 10'h3FC
`define ECCD_CLK_MASK 10'h3E0
`define ECCD_SYNC_RST 2'h0
`define ECCD_BASE_ZERO 4'h0
`define ECCD_RST_BASE_BLK 4'h0
`define ECCD_RST_BANK_EN 4'hF
`define ECCD_RST_SER_CFG 2'h0
`define ECCD_RST_PRN_CFG 2'h0
`define ECCD_RST_CLK_CFG 1'h1
`define ECCD_RST_PAR_GATE 1'h1
`define ECCD_RST_INVALID 1'h1
`endif

/* design/eccd_sync.v */
`timescale 1ns/100ps
`include "eccd_map.vh"
// two-stage synchroniser for slow static switch levels
module eccd_sync #(
    parameter WIDTH = 16
) (
    ref_clk,
    sys_rst,
    clk_en,
    async_in,
    sync_out
);
    input wire ref_clk;
    input wire sys_rst;
    input wire clk_en;
    input wire [WIDTH-1:0] async_in;
    output wire [WIDTH-1:0] sync_out;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg [1:0] stage_reg;
            always @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    stage_reg <= `ECCD_SYNC_RST;
                end else if (clk_en) begin
                    stage_reg <= {stage_reg[0], async_in[i]};
                end
            end
            assign sync_out[i] = stage_reg[1];
        end
    endgenerate
endmodule // eccd_sync

/* design/eccd_decode.v */
`timescale 1ns/100ps
`include "eccd_map.vh"
module eccd_decode (
    ref_clk,
    sys_rst,
    clk_en,
    sw1_off_n,
    sw2_off_n,
    mem_addr,
    mem_req,
    io_addr,
    io_req,
    mem_parity_err,
    bank_sel,
    mem_base_blk,
    bank_enable,
    parity_err_to_host,
    primary_serial_port_sel,
    secondary_serial_port_sel,
    primary_printer_port_sel,
    secondary_printer_port_sel,
    clk_cal_sel,
    data_oe_n,
    cfg_invalid
);
    input wire ref_clk;
    input wire sys_rst;
    input wire clk_en;
    // switch pins: bit i is position i+1, high means OFF
    input wire [7:0] sw1_off_n;
    input wire [7:0] sw2_off_n;
    input wire [`ECCD_ADDR_W-1:0] mem_addr;
    input wire mem_req;
    input wire [9:0] io_addr;
    input wire io_req;
    input wire mem_parity_err;
    output wire [3:0] bank_sel;
    output wire [3:0] mem_base_blk;
    output wire [3:0] bank_enable;
    output wire parity_err_to_host;
    output wire primary_serial_port_sel;
    output wire secondary_serial_port_sel;
    output wire primary_printer_port_sel;
    output wire secondary_printer_port_sel;
    output wire clk_cal_sel;
    output wire data_oe_n;
    output wire cfg_invalid;

    // ****************************************
    // switch synchronisation
    // ****************************************
    wire [15:0] sw_sync;
    eccd_sync #(.WIDTH(16)) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .async_in({sw2_off_n, sw1_off_n}),
        .sync_out(sw_sync)
    );
    wire [7:0] s1_on;
    wire [7:0] s2_on;
    assign s1_on = ~sw_sync[7:0];
    assign s2_on = ~sw_sync[15:8];

    // ****************************************
    // forbidden settings
    // ****************************************
    // each is flagged, and the decode below treats it as disabled
    wire base_none;
    wire ser_both;
    wire prn_both;
    wire test_on;
    assign base_none = ~|sw_sync[3:0];
    assign ser_both = s2_on[6] && s2_on[7];
    assign prn_both = s2_on[4] && s2_on[5];
    assign test_on = s2_on[3];

    // ****************************************
    // configuration decode
    // ****************************************
    // port codes are {primary, secondary}; zero means not decoded
    localparam PORT_OFF = 2'h0;
    localparam PORT_SEC = 2'h1;
    localparam PORT_PRI = 2'h2;
    reg [3:0] base_blk_next;
    reg [3:0] bank_en_next;
    reg [1:0] ser_cfg_next;
    reg [1:0] prn_cfg_next;
    reg clk_cfg_next;
    reg par_gate_next;
    reg invalid_next;

    always @* begin
        // position one is msb, OFF reads as one
        base_blk_next = {sw_sync[0], sw_sync[1],
            sw_sync[2], sw_sync[3]};
        // bank k enabled by position 8-k; table fills from 8 downward
        bank_en_next = {s1_on[4], s1_on[5],
            s1_on[6], s1_on[7]};
        // forbidden pairs fall to default and leave the port off
        case ({s2_on[6], s2_on[7]})
            2'h2: ser_cfg_next = PORT_PRI;
            2'h1: ser_cfg_next = PORT_SEC;
            default: ser_cfg_next = PORT_OFF;
        endcase
        // factory-test position overrides the printer decode
        if (test_on) begin
            prn_cfg_next = PORT_OFF;
        end else begin
            case ({s2_on[5], s2_on[4]})
                2'h2: prn_cfg_next = PORT_PRI;
                2'h1: prn_cfg_next = PORT_SEC;
                default: prn_cfg_next = PORT_OFF;
            endcase
        end
        clk_cfg_next = s2_on[1];
        par_gate_next = s2_on[0];
        invalid_next = base_none || ser_both || prn_both || test_on;
    end

    // ****************************************
    // configuration register
    // ****************************************
    // a stage after the synchroniser so configuration outputs leave a flop;
    // costs one edge of switch latency, harmless for static levels
    reg [3:0] base_blk_reg;
    reg [3:0] bank_en_reg;
    reg [1:0] ser_cfg_reg;
    reg [1:0] prn_cfg_reg;
    reg clk_cfg_reg;
    reg par_gate_reg;
    reg invalid_reg;

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // matches the synchroniser's all-ON reset reading
            base_blk_reg <= `ECCD_RST_BASE_BLK;
            bank_en_reg <= `ECCD_RST_BANK_EN;
            ser_cfg_reg <= `ECCD_RST_SER_CFG;
            prn_cfg_reg <= `ECCD_RST_PRN_CFG;
            clk_cfg_reg <= `ECCD_RST_CLK_CFG;
            par_gate_reg <= `ECCD_RST_PAR_GATE;
            invalid_reg <= `ECCD_RST_INVALID;
        end else if (clk_en) begin
            base_blk_reg <= base_blk_next;
            bank_en_reg <= bank_en_next;
            ser_cfg_reg <= ser_cfg_next;
            prn_cfg_reg <= prn_cfg_next;
            clk_cfg_reg <= clk_cfg_next;
            par_gate_reg <= par_gate_next;
            invalid_reg <= invalid_next;
        end
    end

    assign mem_base_blk = base_blk_reg;
    assign bank_enable = bank_en_reg;
    assign cfg_invalid = invalid_reg;

    // ****************************************
    // memory decode
    // ****************************************
    wire [3:0] addr_blk;
    wire [3:0] blk_off;
    wire base_zero;
    wire in_range;
    wire mem_hit;
    assign addr_blk = mem_addr[`ECCD_ADDR_W-1:`ECCD_BLK_LSB];
    assign blk_off = addr_blk - base_blk_reg;
    // an all-ON base would overlay low memory; keep the card silent
    assign base_zero = (base_blk_reg == `ECCD_BASE_ZERO);
    assign in_range = (addr_blk >= base_blk_reg) && !base_zero;
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_bank
            // bank k counted from base; banks fill from bank 0
            assign bank_sel[b] = mem_req && in_range &&
                (blk_off == b) && bank_en_reg[b];
        end
    endgenerate
    // limitation: dense fill assumed; a gap in enables shifts nothing
    assign mem_hit = |bank_sel;

    // ****************************************
    // parity gate
    // ****************************************
    // passed through after reset: switch OFF masks errors
    assign parity_err_to_host = mem_parity_err && par_gate_reg;

    // ****************************************
    // i/o decode
    // ****************************************
    // the low address bits pick a register inside each port
    wire [9:0] ser_a;
    wire [9:0] prn_a;
    wire [9:0] clk_a;
    wire io_hit;
    assign ser_a = io_addr & `ECCD_SER_MASK;
    assign prn_a = io_addr & `ECCD_PRN_MASK;
    assign clk_a = io_addr & `ECCD_CLK_MASK;
    assign primary_serial_port_sel = io_req && ser_cfg_reg[1] &&
        (ser_a == `ECCD_PRI_SER_BASE);
    assign secondary_serial_port_sel = io_req && ser_cfg_reg[0] &&
        (ser_a == `ECCD_SEC_SER_BASE);
    assign primary_printer_port_sel = io_req && prn_cfg_reg[1] &&
        (prn_a == `ECCD_PRI_PRN_BASE);
    assign secondary_printer_port_sel = io_req && prn_cfg_reg[0] &&
        (prn_a == `ECCD_SEC_PRN_BASE);
    // disabled calendar stays off the bus so another can answer
    assign clk_cal_sel = io_req && clk_cfg_reg &&
        (clk_a == `ECCD_CLK_BASE);

    // ****************************************
    // data bus enable
    // ****************************************
    // the card drives data only for its own selects, so a second
    // card with the same functions disabled can share the bus
    assign io_hit = primary_serial_port_sel || secondary_serial_port_sel ||
        primary_printer_port_sel || secondary_printer_port_sel ||
        clk_cal_sel;
    assign data_oe_n = !(mem_hit || io_hit);
endmodule // eccd_decode

/* verification/eccd_decode_checker.sv */
`timescale 1ns/100ps
module eccd_decode_checker (
    input wire ref_clk, sys_rst, mem_req, io_req, mem_parity_err,
    input wire [7:0] sw1_off_n,
    input wire [9:0] io_addr,
    input wire [3:0] bank_sel, mem_base_blk, bank_enable,
    input wire parity_err_to_host, clk_cal_sel, data_oe_n, cfg_invalid,
    input wire primary_serial_port_sel, primary_printer_port_sel
);
    wire [7:0] s = sw1_off_n;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // five quiet edges outlast the synchroniser and the output register
    sequence q; $stable(s)[*5]; endsequence
    property p_ena; q |-> bank_enable == ~{s[4], s[5], s[6], s[7]}; endproperty
    a_ena: assert property (p_ena) else $error("enable");
    property p_base; q |-> mem_base_blk == {s[0],s[1],s[2],s[3]}; endproperty
    a_base: assert property (p_base) else $error("base");
    property p_par; parity_err_to_host |-> mem_parity_err; endproperty
    a_par: assert property (p_par) else $error("parity");
    property p_oe; !mem_req && !io_req |-> data_oe_n; endproperty
    a_oe: assert property (p_oe) else $error("idle drive");
    property p_bk; |bank_sel |-> mem_req && $onehot(bank_sel); endproperty
    a_bk: assert property (p_bk) else $error("bank");
    property p_ser; primary_serial_port_sel |-> io_addr[9:3] == 7'h7F;
    endproperty
    a_ser: assert property (p_ser) else $error("serial");
    property p_prn; primary_printer_port_sel |-> io_addr[9:2] == 8'hEF;
    endproperty
    a_prn: assert property (p_prn) else $error("printer");
    property p_cal; clk_cal_sel |-> io_req && io_addr[9:5] == 5'h16;
    endproperty
    a_cal: assert property (p_cal) else $error("calendar");
    property p_inv; q ##0 (s[3:0] == 4'h0) |->
        cfg_invalid && bank_sel == 4'h0; endproperty
    a_inv: assert property (p_inv) else $error("base zero");
endmodule // eccd_decode_checker
bind eccd_decode eccd_decode_checker eccd_decode_checker_inst (.*);

/* verification/eccd_host_model.sv */
`timescale 1ns/100ps
module eccd_host_model (
    input wire ref_clk,
    output logic [19:0] mem_addr = 20'h0,
    output logic [9:0] io_addr = 10'h0,
    output logic mem_req = 1'b0, io_req = 1'b0
);
    // released address lines flip so no stale value can pass for a hit
    task put(input logic m, r, input logic [19:0] x);
        @(negedge ref_clk);
        {mem_req, io_req} = {r & m, r & !m};
        mem_addr = m ? x : ~mem_addr;
        io_addr = m ? ~io_addr : x[9:0];
    endtask
endmodule // eccd_host_model

/* verification/eccd_decode_bench.sv */
`timescale 1ns/100ps
module eccd_decode_bench;
    logic ref_clk = 0, sys_rst = 1, mem_req, io_req, e;
    logic pe, cv, oe, ps, ss, pp, sp, cs, pi = 1'b1;
    logic [7:0] a = 8'hFF, b = 8'hFF;
    logic [19:0] mem_addr;
    logic [9:0] io_addr, adr [5] = '{10'h3F8, 10'h2F8, 10'h3BC, 10'h37A, 10'h2C5};
    logic [3:0] bs, bb, be, c;
    logic [4:0] en;
    int bad_count = 0, comparisons = 0;
    initial forever #2.5 ref_clk = ~ref_clk;
    eccd_host_model eccd_host_model_inst (.ref_clk, .mem_addr, .io_addr,
        .mem_req, .io_req);
    eccd_decode eccd_decode_inst (.ref_clk, .sys_rst, .clk_en(1'b1),
        .sw1_off_n(a), .sw2_off_n(b), .mem_addr, .mem_req, .io_addr,
        .io_req, .mem_parity_err(pi), .bank_sel(bs), .mem_base_blk(bb),
        .bank_enable(be), .parity_err_to_host(pe), .cfg_invalid(cv),
        .primary_serial_port_sel(ps), .secondary_serial_port_sel(ss),
        .primary_printer_port_sel(pp), .secondary_printer_port_sel(sp),
        .clk_cal_sel(cs), .data_oe_n(oe));
    task ck(input logic [15:0] s, x);
        comparisons++;
        if (s !== x) bad_count++;
        if (s !== x) $display("Error %0t %h %h", $time, s, x);
    endtask
    task sw(input logic [7:0] s1, s2, input logic p = 1'b1);
        eccd_host_model_inst.put(0, 0, 0);
        {a, b, pi} = {s1, s2, p};
        repeat (5) @(posedge ref_clk);
    endtask
    task go(input logic m, input logic [19:0] x);
        eccd_host_model_inst.put(m, 1, x);
        #1;
    endtask
    task print_verdict;
        if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20 sys_rst = 0;
        for (int i = 1; i < 5; i++) begin
            sw({4'hF >> i, 4'h3}, 8'hFF);
            go(1, 20'hE1234);
            ck({cv, oe, bb, be, bs}, {1'b0, i < 3, 4'hC,
                4'hF >> (4 - i), 1'b0, i > 2, 2'h0});
        end
        go(1, 20'hB0000);
        ck({oe, bs}, 5'h10);
        sw(8'h00, 8'hFF);
        go(1, 20'h10000);
        ck({cv, bs}, 5'h10);
        for (int i = 0; i < 10; i++) begin
            c = i;
            e = c[2];
            en = {c[1:0] == 2, c[1:0] == 1,
                {c[1:0] == 1, c[1:0] == 2} & {2{i < 8}}, !e};
            sw(8'hFF, {c[1:0], c[1:0], i < 8, 1'b1, e, e}, i[0]);
            ck({cv, pe}, {c[1:0] == 0 || i > 7,
                !e && i[0]});
            for (int j = 0; j < 5; j++) begin
                go(0, adr[j]);
                ck({ps, ss, pp, sp, cs, oe},
                    {en & (5'h10 >> j), !en[4 - j]});
            end
        end
        print_verdict;
    end
endmodule // eccd_decode_bench
